// >>> core/iep_bank.sv
// interrupt enable and priority register bank with AHB-Lite slave
//
// Contract
// - enable 1 passes request, 0 blocks
// - priority code 111 gives level 7
// - code 001 level 1, linear between
// - priority code 000 disables source completely
// - unimplemented bits read zero, ignore writes
// - enable bits read/write, reset to zero
// - priority fields reset to 100, level 4
// - enable reg 3 bit positions as listed
// - enable reg 4 bit positions as listed
// - enable reg 5 bit positions as listed
// - priority reg 0 four fields placed
// - priority reg 1 three fields, low unimplemented
// - separator bits 15,11,7,3 read zero
`timescale 1ns/1ps
`include "iep_params.svh"

module iep_bank
    import iep_pkg::*;
#(
    parameter int NUM_IEC  = 3,
    parameter int NUM_IPC  = 2,
    parameter int NUM_PRIO = 7
)(
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic      [31:0]               hrdata,
    output logic                           hreadyout,
    output logic                           hresp,
    input  wire logic [NUM_IEC-1:0][15:0]  en_src_flag,
    input  wire logic [NUM_PRIO-1:0]       prio_src_flag,
    output logic      [NUM_IEC-1:0][15:0]  en_src_req,
    output logic      [NUM_PRIO-1:0]       prio_src_req,
    output logic      [NUM_PRIO-1:0][2:0]  prio_src_level,
    output logic                           irq
);

    localparam logic [NUM_IEC-1:0][7:0] IEC_OFF =
        {`IEP_OFF_EN5, `IEP_OFF_EN4, `IEP_OFF_EN3};
    localparam logic [NUM_IEC-1:0][15:0] IEC_MASK =
        {`IEP_MASK_EN5, `IEP_MASK_EN4, `IEP_MASK_EN3};
    localparam logic [NUM_IPC-1:0][7:0] IPC_OFF =
        {`IEP_OFF_PR1, `IEP_OFF_PR0};
    localparam logic [NUM_IPC-1:0][15:0] IPC_MASK =
        {`IEP_MASK_PR1, `IEP_MASK_PR0};
    localparam logic [NUM_IPC-1:0][15:0] IPC_RST =
        {`IEP_RST_PR1, `IEP_RST_PR0};

    iep_aph_s                  aph_nxt;
    iep_aph_s                  aph_r;
    iep_word_t [NUM_IEC-1:0]   iec_r;
    iep_word_t [NUM_IEC-1:0]   iec_nxt;
    iep_word_t [NUM_IPC-1:0]   ipc_r;
    iep_word_t [NUM_IPC-1:0]   ipc_nxt;
    iep_stat_t                 sts_r;
    iep_stat_t                 sts_nxt;
    iep_stat_t                 ien_r;
    iep_stat_t                 ien_nxt;
    iep_stat_t                 clr_w;
    iep_stat_t                 ev_w;
    iep_level_t [NUM_PRIO-1:0] lvl_w;
    logic [NUM_IEC-1:0][15:0]  en_req_nxt;
    logic [NUM_PRIO-1:0]       prio_req_nxt;
    logic                      wr_w;
    logic [31:0]               rd_nxt;

    // hit() decodes writes only; reads and the unmapped check each decode the address on their own
    function automatic logic hit(input iep_aph_s a, input logic [7:0] off);
        hit = a.valid && a.hi_zero && (a.addr == off);
    endfunction : hit

    function automatic logic mapped(input iep_aph_s a);
        mapped = a.hi_zero && (a.addr inside {`IEP_OFF_EN3, `IEP_OFF_EN4,
                 `IEP_OFF_EN5, `IEP_OFF_PR0, `IEP_OFF_PR1,
                 `IEP_OFF_STAT, `IEP_OFF_CLR, `IEP_OFF_IEN});
    endfunction : mapped

    // address phase capture; slave never inserts wait states
    always_comb
    begin
        aph_nxt.valid   = hsel && htrans[`IEP_TRANS_ACT] && hready;
        aph_nxt.write   = hwrite;
        aph_nxt.hi_zero = (haddr[31:8] == 24'h000000);
        aph_nxt.addr    = haddr[7:0];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            aph_r <= '0;
        else
            aph_r <= aph_nxt;
    end

    assign wr_w = aph_r.valid && aph_r.write;

    // enable registers; unimplemented positions masked off on write
    generate
        for (genvar k = 0; k < NUM_IEC; k++)
        begin : g_iec
            always_comb
            begin
                iec_nxt[k] = iec_r[k];
                if (wr_w && hit(aph_r, IEC_OFF[k]))
                    iec_nxt[k] = hwdata[15:0] & IEC_MASK[k];
            end

            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    iec_r[k] <= `IEP_RST_IEC;
                else
                    iec_r[k] <= iec_nxt[k];
            end
        end
    endgenerate

    // priority registers; separator bits never store a one
    generate
        for (genvar k = 0; k < NUM_IPC; k++)
        begin : g_ipc
            always_comb
            begin
                ipc_nxt[k] = ipc_r[k];
                if (wr_w && hit(aph_r, IPC_OFF[k]))
                    ipc_nxt[k] = hwdata[15:0] & IPC_MASK[k];
            end

            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    ipc_r[k] <= IPC_RST[k];
                else
                    ipc_r[k] <= ipc_nxt[k];
            end
        end
    endgenerate

    // field extraction: the code is the level, 000 means off
    generate
        for (genvar i = 0; i < NUM_PRIO; i++)
        begin : g_lvl
            localparam int REG = i / `IEP_PRIO_PER_REG;
            localparam int LSB = `IEP_PRIO_TOP_LSB
                               - `IEP_PRIO_STRIDE * (i % `IEP_PRIO_PER_REG);
            assign lvl_w[i] = ipc_r[REG][LSB +: 3];
            assign prio_req_nxt[i] = prio_src_flag[i]
                                  && (lvl_w[i] != `IEP_LVL_OFF);
        end
    endgenerate

    // enable gating; a cleared enable blocks the flag outright
    assign en_req_nxt = en_src_flag & iec_r;

    // requests and levels registered so the core sees clean levels
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            en_src_req     <= '0;
            prio_src_req   <= '0;
            prio_src_level <= '0;
        end
        else
        begin
            en_src_req     <= en_req_nxt;
            prio_src_req   <= prio_req_nxt;
            prio_src_level <= lvl_w;
        end
    end

    // events: rising request on either side, or an unmapped access
    always_comb
    begin
        ev_w = '0;
        ev_w[`IEP_ST_EN_REQ]   = |(en_req_nxt & ~en_src_req);
        ev_w[`IEP_ST_PRIO_REQ] = |(prio_req_nxt & ~prio_src_req);
        ev_w[`IEP_ST_UNMAPPED] = aph_r.valid && !mapped(aph_r);
    end

    // write-one-to-clear; a same-cycle event still wins
    always_comb
    begin
        clr_w = '0;
        if (wr_w && hit(aph_r, `IEP_OFF_CLR))
            clr_w = hwdata[2:0];
        sts_nxt = (sts_r & ~clr_w) | ev_w;
        ien_nxt = ien_r;
        if (wr_w && hit(aph_r, `IEP_OFF_IEN))
            ien_nxt = hwdata[2:0];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sts_r <= '0;
            ien_r <= '0;
            irq   <= 1'b0;
        end
        else
        begin
            sts_r <= sts_nxt;
            ien_r <= ien_nxt;
            irq   <= |(sts_nxt & ien_nxt);
        end
    end

    // read data built from next values, so a read right after a
    // write to the same word sees the new contents
    always_comb
    begin
        rd_nxt = '0;
        if (aph_nxt.valid && !aph_nxt.write && aph_nxt.hi_zero)
        begin
            case (aph_nxt.addr)
                `IEP_OFF_EN3:  rd_nxt[15:0] = iec_nxt[0];
                `IEP_OFF_EN4:  rd_nxt[15:0] = iec_nxt[1];
                `IEP_OFF_EN5:  rd_nxt[15:0] = iec_nxt[2];
                `IEP_OFF_PR0:  rd_nxt[15:0] = ipc_nxt[0];
                `IEP_OFF_PR1:  rd_nxt[15:0] = ipc_nxt[1];
                `IEP_OFF_STAT: rd_nxt[2:0]  = sts_nxt;
                `IEP_OFF_IEN:  rd_nxt[2:0]  = ien_nxt;
                default:       rd_nxt       = '0; // clear reg reads zero
            endcase
        end
    end

    // bus answer: always ready, always OKAY
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata    <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hrdata    <= rd_nxt;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // checks on the design's own registers and outputs
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_wr_en3;
        aph_nxt.valid && aph_nxt.write && aph_nxt.hi_zero
            && aph_nxt.addr == `IEP_OFF_EN3;
    endsequence

    sequence s_rd_pr0;
        aph_nxt.valid && !aph_nxt.write && aph_nxt.hi_zero
            && aph_nxt.addr == `IEP_OFF_PR0;
    endsequence

    sequence s_rd_clr;
        aph_nxt.valid && !aph_nxt.write && aph_nxt.hi_zero
            && aph_nxt.addr == `IEP_OFF_CLR;
    endsequence

    a_en_blocks_req: assert property (
        !iec_r[0][14] |=> !en_src_req[0][14])
        else $error("disabled source passed a request");

    a_en_passes_req: assert property (
        en_src_flag[0][14] && iec_r[0][14] |=> en_src_req[0][14])
        else $error("enabled source request lost");

    a_zero_level_off: assert property (
        lvl_w[0] == 3'h0 |=> !prio_src_req[0])
        else $error("level zero source raised a request");

    a_level_follows: assert property (
        prio_src_req[0] |-> prio_src_level[0] == $past(ipc_r[0][14:12])
            && prio_src_level[0] != 3'h0)
        else $error("request level does not match field");

    a_iec_write_lands: assert property (
        s_wr_en3 ##1 1'b1 |=>
            iec_r[0] == ($past(hwdata[15:0]) & `IEP_MASK_EN3))
        else $error("enable write did not land masked");

    a_ipc_read_gaps: assert property (
        s_rd_pr0 |=> hrdata[31:16] == 16'h0000
            && (hrdata[15:0] & ~`IEP_MASK_PR0) == 16'h0000)
        else $error("unimplemented priority bits read nonzero");

    a_irq_priority_ctrl_1_low_zero: assert property (
        ipc_r[1][3:0] == 4'h0 && ipc_r[1][15] == 1'b0)
        else $error("unimplemented bits of priority reg 1 set");

    a_iec_masks: assert property (
        (iec_r[1] & ~`IEP_MASK_EN4) == 16'h0000
            && (iec_r[2] & ~`IEP_MASK_EN5) == 16'h0000)
        else $error("unimplemented enable bit set");

    a_irq_level: assert property (
        |(sts_r & ien_r) |-> irq)
        else $error("enabled status bit without interrupt");

    a_set_beats_clr: assert property (
        ev_w[`IEP_ST_UNMAPPED] |=> sts_r[`IEP_ST_UNMAPPED] [*1])
        else $error("event lost against clear");

    // the master waits on hready, so a lasting stall would hang it and an error go unseen
    a_bus_okay: assert property (
        hreadyout && !hresp)
        else $error("slave stalled or answered an error");

    // a request event beats a clear landing in the same cycle
    a_en_ev_wins: assert property (
        ev_w[`IEP_ST_EN_REQ] |=> sts_r[`IEP_ST_EN_REQ])
        else $error("request event lost against clear");

    // separators of priority reg 0 never hold a one
    a_irq_priority_ctrl_0_gaps: assert property (
        (ipc_r[0] & ~`IEP_MASK_PR0) == 16'h0000)
        else $error("separator bit of priority reg 0 set");

    // enable reg 3 keeps only its listed positions
    a_en3_mask: assert property (
        (iec_r[0] & ~`IEP_MASK_EN3) == 16'h0000)
        else $error("unimplemented bit of enable reg 3 set");

    // clear register is write-only and reads back zero
    a_clr_reads_zero: assert property (
        s_rd_clr |=> hrdata == 32'h00000000)
        else $error("clear register read nonzero");

endmodule : iep_bank

// >>> core/iep_params.svh
// offsets, masks, reset values and field positions of the enable/priority bank
`ifndef IEP_PARAMS_SVH
`define IEP_PARAMS_SVH

// byte offsets on the register bus
`define IEP_OFF_EN3       8'h00
`define IEP_OFF_EN4       8'h04
`define IEP_OFF_EN5       8'h08
`define IEP_OFF_PR0       8'h0c
`define IEP_OFF_PR1       8'h10
`define IEP_OFF_STAT      8'h14
`define IEP_OFF_CLR       8'h18
`define IEP_OFF_IEN       8'h1c

// implemented bits of each enable register and their common reset value
`define IEP_MASK_EN3      16'h4066
`define IEP_MASK_EN4      16'h210e
`define IEP_MASK_EN5      16'h3fbe
`define IEP_RST_IEC       16'h0000

// implemented bits and reset values of the priority registers
`define IEP_MASK_PR0      16'h7777
`define IEP_MASK_PR1      16'h7770
`define IEP_RST_PR0       16'h4444
`define IEP_RST_PR1       16'h4440

// priority field layout: 3-bit fields every 4 bits, top one at bit 12
`define IEP_PRIO_TOP_LSB  12
`define IEP_PRIO_STRIDE   4
`define IEP_PRIO_PER_REG  4
`define IEP_LVL_OFF       3'h0

// interrupt status bit positions
`define IEP_ST_EN_REQ     0
`define IEP_ST_PRIO_REQ   1
`define IEP_ST_UNMAPPED   2

// htrans bit that marks NONSEQ or SEQ
`define IEP_TRANS_ACT     1

`endif

// >>> core/iep_pkg.sv
// shared types of the enable/priority bank
package iep_pkg;

    typedef logic [15:0] iep_word_t;
    typedef logic [2:0]  iep_level_t;
    typedef logic [2:0]  iep_stat_t;

    // captured AHB address phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic       hi_zero;
        logic [7:0] addr;
    } iep_aph_s;

endpackage : iep_pkg

// >>> tb/iep_src_model.sv
// far-side model: peripheral flag sources feeding the bank
`timescale 1ns/1ps
module iep_src_model
    import iep_pkg::*;
(
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             routed,
    input  wire logic [2:0][15:0] en_set,
    input  wire logic [6:0]       prio_set,
    output logic      [2:0][15:0] en_src_flag,
    output logic      [6:0]       prio_src_flag
);
    // flags move just after the edge, as a real source would
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            en_src_flag   <= '0;
            prio_src_flag <= '0;
        end
        else
        begin
            en_src_flag   <= en_set;
            prio_src_flag <= prio_set;
            // an unrouted external input sees no signal at all
            if (!routed)
            begin
                en_src_flag[0][6:5] <= 2'h0;
                prio_src_flag[3]    <= 1'b0;
            end
        end
    end
endmodule : iep_src_model

// >>> tb/tb_top.sv
// self-checking bench of the enable/priority bank
`timescale 1ns/1ps
`include "iep_params.svh"
module tb_top
    import iep_pkg::*;
;
    logic             hclk;
    logic             hresetn;
    logic             hsel;
    logic [31:0]      haddr;
    logic [1:0]       htrans;
    logic             hwrite;
    logic [31:0]      hwdata;
    logic [31:0]      hrdata;
    logic             hreadyout;
    logic             hresp;
    logic             routed;
    logic [2:0][15:0] en_set;
    logic [6:0]       prio_set;
    logic [2:0][15:0] en_src_flag;
    logic [6:0]       prio_src_flag;
    logic [2:0][15:0] en_src_req;
    logic [6:0]       prio_src_req;
    logic [6:0][2:0]  prio_src_level;
    logic             irq;
    logic [31:0]      rd;
    logic [31:0]      hrdata_s;
    logic [7:0]       offs [5];
    logic [15:0]      msk [5];
    logic [15:0]      rst [5];
    int               n_fail;
    int               total_checks;
    int               cycles;

    iep_bank i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .en_src_flag(en_src_flag),
        .prio_src_flag(prio_src_flag), .en_src_req(en_src_req),
        .prio_src_req(prio_src_req), .prio_src_level(prio_src_level),
        .irq(irq));
    iep_src_model i_src (.hclk(hclk), .hresetn(hresetn), .routed(routed),
        .en_set(en_set), .prio_set(prio_set), .en_src_flag(en_src_flag),
        .prio_src_flag(prio_src_flag));

    // free-running clock, 100 ns period
    initial
    begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    // read data copied mid-cycle, so the edge that ends the data
    // phase cannot race the slave's next update of hrdata
    always @(negedge hclk)
        hrdata_s = hrdata;

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : print_verdict

    // hang guard, far above the roughly 120 cycles the tests need
    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch %s exp %h got %h", nm, exp, got);
        end
    endtask : chk

    // one AHB-Lite single transfer; waits on hready in both phases
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rdv);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdv = hrdata_s;
    endtask : bus

    // requests show one edge after the register, irq on that same edge
    task automatic settle();
        repeat (3) @(posedge hclk);
    endtask : settle

    initial
    begin
        offs = '{`IEP_OFF_EN3, `IEP_OFF_EN4, `IEP_OFF_EN5,
                 `IEP_OFF_PR0, `IEP_OFF_PR1};
        msk  = '{`IEP_MASK_EN3, `IEP_MASK_EN4, `IEP_MASK_EN5,
                 16'h7777, 16'h7770};
        rst  = '{16'h0000, 16'h0000, 16'h0000, 16'h4444, 16'h4440};
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        routed = 1'b0;
        en_set = '0;
        prio_set = '0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        settle();
        chk("levels", 32'(prio_src_level), 32'({7{3'h4}}));
        // reset values, then all-ones reads back only implemented bits
        for (int i = 0; i < 5; i++)
        begin
            bus(1'b0, offs[i], 32'h0, rd);
            chk("reset", rd, {16'h0000, rst[i]});
            bus(1'b1, offs[i], 32'hffffffff, rd);
            bus(1'b0, offs[i], 32'h0, rd);
            chk("ones", rd, {16'h0000, msk[i]});
        end
        $display("test registers done");
        // enables all set: requests land exactly on the listed bits
        en_set <= {3{16'hffff}};
        settle();
        chk("unrouted", 32'(en_src_req[0]), 32'h4006);
        routed <= 1'b1;
        settle();
        for (int i = 0; i < 3; i++)
            chk("en req", 32'(en_src_req[i]), 32'(msk[i]));
        for (int i = 0; i < 3; i++)
            bus(1'b1, offs[i], 32'h0, rd);
        settle();
        chk("blocked", 32'(en_src_req), 32'h0);
        $display("test enables done");
        // field placement across both priority registers
        prio_set <= 7'h7f;
        bus(1'b1, `IEP_OFF_PR0, 32'h1234, rd);
        bus(1'b1, `IEP_OFF_PR1, 32'h5670, rd);
        settle();
        chk("fields", 32'(prio_src_level),
            {11'h000, 3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1});
        // every code of one field: level follows code, 000 is off
        for (int c = 0; c < 8; c++)
        begin
            bus(1'b1, `IEP_OFF_PR0, 32'(c * 4096) | 32'h0444, rd);
            settle();
            chk("level", 32'(prio_src_level[0]), 32'(c));
            chk("prio req", 32'(prio_src_req[0]), 32'(c != 0));
        end
        $display("test priorities done");
        // status, unmapped access, enable, clear
        bus(1'b0, 8'h40, 32'h0, rd);
        chk("unmapped", rd, 32'h0);
        bus(1'b0, `IEP_OFF_STAT, 32'h0, rd);
        chk("status", rd, 32'h7);
        bus(1'b1, `IEP_OFF_IEN, 32'h4, rd);
        settle();
        chk("irq on", 32'(irq), 32'h1);
        bus(1'b1, `IEP_OFF_CLR, 32'h3, rd);
        bus(1'b0, `IEP_OFF_STAT, 32'h0, rd);
        chk("cleared", rd, 32'h4);
        bus(1'b1, `IEP_OFF_CLR, 32'h4, rd);
        settle();
        chk("irq off", 32'(irq), 32'h0);
        chk("bus resp", {30'h0, hreadyout, hresp}, 32'h2);
        $display("test interrupt done");
        print_verdict();
    end
endmodule : tb_top
